// ==== logic/cksw_pkg.sv ====
// constants, register map and state encoding for the system clock switch control
//
// Notes on behaviour
// - every oscillator ready shown in status register
// - software forces oscillators on; all eight enable bits writable
// - frequency write clears high/mid ready until ready
// - mid clock held static while frequency change pending
// - internal clocks stay usable; accurate once ready
// - switch-enable config gates request field writes
// - keep current clock until requested source ready
// - source already running counts as ready immediately
// - ready sets flag and irq flag; enable gates irq
// - irq flag never wakes the device from sleep
// - pollable oscillator-ready bit reflects switch done
// - hold clear: switch right after ready flag sets
// - hold set: stay on old clock after ready
// - slow-run mode does not delay the switch
// - divider-only change uses same sequence, needs hold clear
// - current fields keep old value until switch instant
// - hardware clears new-source-ready flag on switch
package cksw_pkg;
  localparam int SRC_W = 3;
  localparam int DIV_W = 4;
  localparam int OSC_N = 8;
  localparam int FRQ_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFF_REQ = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CUR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SWCS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OSTAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_OEN = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FRQ = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IFLAG = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IEN = 8'h1C;

  localparam int SRC_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int NEW_SOURCE_READY_FLAG_BIT = 3;
  localparam int SWITCH_DONE_READY_BIT_BIT = 4;
  localparam int HOLD_BIT = 7;
  localparam int IFLAG_BIT = 0;
  localparam int IEN_BIT = 0;

  localparam int OSC_CONVERTER_RC_OSCILLATOR_IDX = 4;
  localparam int OSC_MF_IDX = 5;
  localparam int OSC_HF_IDX = 6;

  localparam logic [SRC_W-1:0] RST_SRC = 3'h6;
  localparam logic [DIV_W-1:0] RST_DIV = 4'h0;
  localparam logic [FRQ_W-1:0] RST_FRQ = 4'h0;
  localparam logic [OSC_N-1:0] RST_OEN = 8'h00;

  localparam int CLK_PERIOD_NS = 40;
  localparam int FRQ_SETTLE_NS = 160;
  localparam int FRQ_SETTLE_CYC = (FRQ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_READY = 3'h4
  } cksw_state_e;
endpackage : cksw_pkg

// ==== logic/cksw_sw_if.sv ====
// request and status signals between register block and switch sequencer
`timescale 1ns/1ps
interface cksw_sw_if;
  import cksw_pkg::*;
  logic [SRC_W-1:0] req_src;
  logic [DIV_W-1:0] req_div;
  logic hold;
  logic src_ready;
  logic [SRC_W-1:0] cur_src;
  logic [DIV_W-1:0] cur_div;
  logic new_source_ready_flag;
  logic switch_done_ready_bit;
  logic irq_set;
  modport ctrl (output req_src, req_div, hold, src_ready,
                input cur_src, cur_div, new_source_ready_flag, switch_done_ready_bit, irq_set);
  modport seq (input req_src, req_div, hold, src_ready,
               output cur_src, cur_div, new_source_ready_flag, switch_done_ready_bit, irq_set);
endinterface : cksw_sw_if

// ==== logic/cksw_sync.sv ====
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
module cksw_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,           // system clock
  input wire logic i_rst,           // synchronous reset, high
  input wire logic [W-1:0] i_async, // levels from other domains
  output logic [W-1:0] o_sync       // synchronised levels
);
  if (W < 1) begin : g_chk
    $error("cksw_sync: width must be at least one");
  end
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    always_comb begin
      meta_next = i_async[g];
      sync_next = meta_reg;
    end
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
      end
    end
    assign o_sync[g] = sync_reg;
  end
endmodule : cksw_sync

// ==== logic/cksw_seq.sv ====
// clock switch sequencer: request, ready, hold and changeover
`timescale 1ns/1ps
module cksw_seq (
  input wire logic i_clk,  // system clock
  input wire logic i_rst,  // synchronous reset, high
  cksw_sw_if.seq sw        // request and status group
);
  import cksw_pkg::*;
  cksw_state_e state_reg;
  cksw_state_e state_next;
  logic [SRC_W-1:0] cur_src_reg;
  logic [SRC_W-1:0] cur_src_next;
  logic [DIV_W-1:0] cur_div_reg;
  logic [DIV_W-1:0] cur_div_next;
  logic new_source_ready_flag_reg;
  logic new_source_ready_flag_next;
  logic switch_done_ready_bit_reg;
  logic switch_done_ready_bit_next;
  logic irq_set_reg;
  logic irq_set_next;
  logic pending;
  logic same_src;

  always_comb begin
    pending = (sw.req_src != cur_src_reg) || (sw.req_div != cur_div_reg);
    same_src = (sw.req_src == cur_src_reg);
    state_next = state_reg;
    cur_src_next = cur_src_reg;
    cur_div_next = cur_div_reg;
    new_source_ready_flag_next = new_source_ready_flag_reg;
    switch_done_ready_bit_next = switch_done_ready_bit_reg;
    irq_set_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (pending) begin
          state_next = ST_WAIT;
          switch_done_ready_bit_next = 1'b0;
        end
      end
      ST_WAIT: begin
        if (!pending) begin
          state_next = ST_IDLE;
          switch_done_ready_bit_next = 1'b1;
        end else if (same_src || sw.src_ready) begin
          state_next = ST_READY;
          new_source_ready_flag_next = 1'b1;
          irq_set_next = 1'b1;
        end
      end
      ST_READY: begin
        if (!pending) begin
          state_next = ST_IDLE;
          new_source_ready_flag_next = 1'b0;
          switch_done_ready_bit_next = 1'b1;
        end else if (!sw.hold) begin
          state_next = ST_IDLE;
          cur_src_next = sw.req_src;
          cur_div_next = sw.req_div;
          new_source_ready_flag_next = 1'b0;
          switch_done_ready_bit_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      cur_src_reg <= RST_SRC;
      cur_div_reg <= RST_DIV;
      new_source_ready_flag_reg <= 1'b0;
      switch_done_ready_bit_reg <= 1'b1;
      irq_set_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_src_reg <= cur_src_next;
      cur_div_reg <= cur_div_next;
      new_source_ready_flag_reg <= new_source_ready_flag_next;
      switch_done_ready_bit_reg <= switch_done_ready_bit_next;
      irq_set_reg <= irq_set_next;
    end
  end

  assign sw.cur_src = cur_src_reg;
  assign sw.cur_div = cur_div_reg;
  assign sw.new_source_ready_flag = new_source_ready_flag_reg;
  assign sw.switch_done_ready_bit = switch_done_ready_bit_reg;
  assign sw.irq_set = irq_set_reg;

  a_hold_keeps_old: assert property (@(posedge i_clk) disable iff (i_rst)
    (new_source_ready_flag_reg && sw.hold && pending) |=> $stable(cur_src_reg) && $stable(cur_div_reg))
    else $error("clock selection changed while switch held");
  a_cur_only_switch: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(cur_src_reg) |-> $past(state_reg) == ST_READY && switch_done_ready_bit_reg)
    else $error("current source changed outside a switch");
  a_new_source_ready_flag_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
    ($changed(cur_src_reg) || $changed(cur_div_reg)) |-> !new_source_ready_flag_reg)
    else $error("new source ready flag left set after switch");
  a_switch_prompt: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == ST_READY && !sw.hold && pending) |=> cur_div_reg == $past(sw.req_div))
    else $error("switch not taken one cycle after ready");
  a_divider_quick: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == ST_WAIT && same_src && pending) |=> new_source_ready_flag_reg ##0 irq_set_reg)
    else $error("running source not treated as ready at once");
endmodule : cksw_seq

// ==== logic/cksw_top.sv ====
// system clock switch control: APB registers, oscillator ready flags, sequencer
`timescale 1ns/1ps
module cksw_top (
  input wire logic I_SYS_CLK,                              // system clock, 25 MHz
  input wire logic I_RST,                                  // synchronous reset, high
  input wire logic I_PSEL,                                 // APB select
  input wire logic I_PENABLE,                              // APB access phase
  input wire logic I_PWRITE,                               // APB write
  input wire logic [cksw_pkg::ADDR_W-1:0] I_PADDR,         // APB byte address
  input wire logic [cksw_pkg::DATA_W-1:0] I_PWDATA,        // APB write data
  output logic [cksw_pkg::DATA_W-1:0] O_PRDATA,            // APB read data
  output logic O_PREADY,                                   // APB ready
  output logic O_PSLVERR,                                  // APB error, unmapped address
  input wire logic I_CSW_EN,                               // clock switch enable config bit
  input wire logic [cksw_pkg::OSC_N-1:0] I_OSC_READY,      // raw ready per oscillator
  output logic [cksw_pkg::SRC_W-1:0] O_CUR_SRC,            // selected clock source
  output logic [cksw_pkg::DIV_W-1:0] O_CUR_DIV,            // selected post divider
  output logic [cksw_pkg::OSC_N-1:0] O_OSC_FORCE_EN,       // manual oscillator enables
  output logic [cksw_pkg::FRQ_W-1:0] O_FRQ_SEL,            // internal frequency select
  output logic O_MF_HOLD,                                  // hold mid clock at static level
  output logic O_CSW_IRQ                                   // clock switch interrupt request
);
  import cksw_pkg::*;
  localparam int CNT_W = $clog2(FRQ_SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(FRQ_SETTLE_CYC - 1);

  if (OSC_N < (1 << SRC_W) || FRQ_SETTLE_CYC < 1) begin : g_chk
    $error("cksw_top: every source code needs a ready bit");
  end

  cksw_sw_if sw ();
  logic [OSC_N:0] sync_in;
  logic [OSC_N:0] sync_out;
  logic [OSC_N-1:0] osc_rdy;
  logic csw_en;

  assign sync_in = {I_CSW_EN, I_OSC_READY};
  cksw_sync #(.W(OSC_N + 1)) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_async(sync_in),
    .o_sync(sync_out)
  );
  assign osc_rdy = sync_out[OSC_N-1:0];
  assign csw_en = sync_out[OSC_N];

  cksw_seq u_seq (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .sw(sw)
  );

  logic [SRC_W-1:0] req_src_reg;
  logic [SRC_W-1:0] req_src_next;
  logic [DIV_W-1:0] req_div_reg;
  logic [DIV_W-1:0] req_div_next;
  logic hold_reg;
  logic hold_next;
  logic [OSC_N-1:0] oen_reg;
  logic [OSC_N-1:0] oen_next;
  logic [FRQ_W-1:0] frq_reg;
  logic [FRQ_W-1:0] frq_next;
  logic frq_pend_reg;
  logic frq_pend_next;
  logic [CNT_W-1:0] settle_reg;
  logic [CNT_W-1:0] settle_next;
  logic mf_hold_reg;
  logic mf_hold_next;
  logic iflag_reg;
  logic iflag_next;
  logic ien_reg;
  logic ien_next;
  logic irq_reg;
  logic irq_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic slverr_reg;
  logic slverr_next;
  logic [OSC_N-1:0] ostat;
  logic setup;
  logic wr;
  logic mapped;

  assign sw.req_src = req_src_reg;
  assign sw.req_div = req_div_reg;
  assign sw.hold = hold_reg;
  assign sw.src_ready = osc_rdy[sw.req_src];

  // status view: high/mid ready masked while a frequency change settles
  always_comb begin
    ostat = osc_rdy;
    ostat[OSC_HF_IDX] = osc_rdy[OSC_HF_IDX] && !frq_pend_reg;
    ostat[OSC_MF_IDX] = osc_rdy[OSC_MF_IDX] && !frq_pend_reg;
  end

  // write acts on the access edge; pready is high from the first cycle after reset so no wait states
  always_comb begin
    setup = I_PSEL && !I_PENABLE;
    wr = I_PSEL && I_PENABLE && pready_reg && I_PWRITE;
    case (I_PADDR)
      OFF_REQ, OFF_CUR, OFF_SWCS, OFF_OSTAT, OFF_OEN, OFF_FRQ, OFF_IFLAG, OFF_IEN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    req_src_next = req_src_reg;
    req_div_next = req_div_reg;
    hold_next = hold_reg;
    oen_next = oen_reg;
    frq_next = frq_reg;
    ien_next = ien_reg;
    if (wr && I_PADDR == OFF_REQ && csw_en) begin
      req_src_next = I_PWDATA[SRC_LSB +: SRC_W];
      req_div_next = I_PWDATA[DIV_LSB +: DIV_W];
    end
    if (wr && I_PADDR == OFF_SWCS) begin
      hold_next = I_PWDATA[HOLD_BIT];
    end
    if (wr && I_PADDR == OFF_OEN) begin
      oen_next = I_PWDATA[OSC_N-1:0];
    end
    if (wr && I_PADDR == OFF_IEN) begin
      ien_next = I_PWDATA[IEN_BIT];
    end
    frq_pend_next = frq_pend_reg;
    settle_next = settle_reg;
    if (wr && I_PADDR == OFF_FRQ && I_PWDATA[FRQ_W-1:0] != frq_reg) begin
      frq_next = I_PWDATA[FRQ_W-1:0];
      frq_pend_next = 1'b1;
      settle_next = '0;
    end else if (frq_pend_reg) begin
      // raw ready may lag the new setting, so wait a fixed settle time first
      if (settle_reg != SETTLE_LAST) begin
        settle_next = settle_reg + CNT_W'(1);
      end else if (osc_rdy[OSC_HF_IDX]) begin
        frq_pend_next = 1'b0;
      end
    end
    mf_hold_next = frq_pend_next;
    // a new event beats a same-cycle write-one-to-clear
    iflag_next = sw.irq_set || (iflag_reg && !(wr && I_PADDR == OFF_IFLAG
                 && I_PWDATA[IFLAG_BIT]));
    // plain request line, no path into the wake logic
    irq_next = iflag_reg && ien_reg;
    pready_next = 1'b1;
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (setup) begin
      slverr_next = !mapped;
      prdata_next = '0;
      case (I_PADDR)
        OFF_REQ: begin
          prdata_next[SRC_LSB +: SRC_W] = req_src_reg;
          prdata_next[DIV_LSB +: DIV_W] = req_div_reg;
        end
        OFF_CUR: begin
          prdata_next[SRC_LSB +: SRC_W] = sw.cur_src;
          prdata_next[DIV_LSB +: DIV_W] = sw.cur_div;
        end
        OFF_SWCS: begin
          prdata_next[HOLD_BIT] = hold_reg;
          prdata_next[SWITCH_DONE_READY_BIT_BIT] = sw.switch_done_ready_bit;
          prdata_next[NEW_SOURCE_READY_FLAG_BIT] = sw.new_source_ready_flag;
        end
        OFF_OSTAT: prdata_next[OSC_N-1:0] = ostat;
        OFF_OEN: prdata_next[OSC_N-1:0] = oen_reg;
        OFF_FRQ: prdata_next[FRQ_W-1:0] = frq_reg;
        OFF_IFLAG: prdata_next[IFLAG_BIT] = iflag_reg;
        OFF_IEN: prdata_next[IEN_BIT] = ien_reg;
        default: prdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      req_src_reg <= RST_SRC;
      req_div_reg <= RST_DIV;
      hold_reg <= 1'b0;
      oen_reg <= RST_OEN;
      frq_reg <= RST_FRQ;
      frq_pend_reg <= 1'b0;
      settle_reg <= '0;
      mf_hold_reg <= 1'b0;
      iflag_reg <= 1'b0;
      ien_reg <= 1'b0;
      irq_reg <= 1'b0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      slverr_reg <= 1'b0;
    end else begin
      req_src_reg <= req_src_next;
      req_div_reg <= req_div_next;
      hold_reg <= hold_next;
      oen_reg <= oen_next;
      frq_reg <= frq_next;
      frq_pend_reg <= frq_pend_next;
      settle_reg <= settle_next;
      mf_hold_reg <= mf_hold_next;
      iflag_reg <= iflag_next;
      ien_reg <= ien_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      slverr_reg <= slverr_next;
    end
  end

  assign O_PRDATA = prdata_reg;
  assign O_PREADY = pready_reg;
  assign O_PSLVERR = slverr_reg;
  assign O_CUR_SRC = sw.cur_src;
  assign O_CUR_DIV = sw.cur_div;
  assign O_OSC_FORCE_EN = oen_reg;
  assign O_FRQ_SEL = frq_reg;
  assign O_MF_HOLD = mf_hold_reg;
  assign O_CSW_IRQ = irq_reg;

  a_request_locked: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !csw_en |=> $stable(req_src_reg) && $stable(req_div_reg))
    else $error("request fields changed with switching disabled");
  a_flag_set_wins: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    sw.irq_set |=> iflag_reg)
    else $error("switch event lost from interrupt flag");
  a_irq_gated: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_CSW_IRQ |-> $past(iflag_reg) && $past(ien_reg))
    else $error("interrupt raised without flag and enable");
  a_frq_ready_clear: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (wr && I_PADDR == OFF_FRQ && I_PWDATA[FRQ_W-1:0] != frq_reg)
    |=> !ostat[OSC_HF_IDX] && !ostat[OSC_MF_IDX] [*4])
    else $error("high or mid ready not cleared during settle");
  a_mf_hold_pend: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_MF_HOLD == frq_pend_reg)
    else $error("mid clock hold not tracking pending change");
  a_apb_zero_wait: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (I_PSEL && !I_PENABLE) |=> O_PREADY)
    else $error("APB access phase not ready");
endmodule : cksw_top

// ==== testbench/cksw_osc_model.sv ====
// oscillator sources: ready levels after a start-up delay
`timescale 1ns/1ps
module cksw_osc_model (
  input wire logic i_clk,            // system clock
  input wire logic i_rst,            // bench reset
  input wire logic [7:0] i_run,      // oscillators in use
  input wire logic [7:0] i_force_en, // manual enables from the block
  input wire logic [3:0] i_frq_sel,  // internal frequency select
  input wire logic [7:0] i_delay,    // start-up cycles
  output logic [7:0] o_ready         // raw ready levels
);
  logic [7:0] cnt [8];
  logic [3:0] frq_last;

  always @(posedge i_clk) begin
    frq_last <= i_frq_sel;
    for (int k = 0; k < 8; k++) begin
      // a retune restarts the internal pair, so ready drops until it relocks
      if (i_rst || !(i_run[k] || i_force_en[k]) ||
          ((k == 5 || k == 6) && i_frq_sel !== frq_last)) begin
        cnt[k] <= 8'h00;
        o_ready[k] <= 1'b0;
      end else if (cnt[k] < i_delay) begin
        cnt[k] <= cnt[k] + 8'h01;
      end else begin
        o_ready[k] <= 1'b1;
      end
    end
  end
endmodule : cksw_osc_model

// ==== testbench/cksw_tb_top.sv ====
// self-checking bench for the clock switch control with an oscillator model
`timescale 1ns/1ps
module cksw_tb_top;
  import cksw_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, csw_en = 1'b1;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, mf_hold, irq, err;
  logic [SRC_W-1:0] cur_src;
  logic [DIV_W-1:0] cur_div;
  logic [OSC_N-1:0] force_en, osc_rdy, run = 8'h60;
  logic [FRQ_W-1:0] frq_sel;
  logic [7:0] dly = 8'h03;
  logic [31:0] seed = 32'h0000_0048;
  logic [7:0] regs_q[$] = '{OFF_REQ, OFF_CUR, OFF_SWCS, OFF_OSTAT, OFF_OEN, OFF_FRQ,
                            OFF_IFLAG, OFF_IEN};
  int mismatches = 0, tests_run = 0, n;
  int m_rsrc = 6, m_rdiv = 0, m_src = 6, m_div = 0, m_hold = 0, m_switch_done_ready_bit = 1, m_new_source_ready_flag = 0;
  int m_oen = 0, m_frq = 0, m_flag = 0, m_ien = 0, m_run = 96;

  always #20 clk = ~clk;

  cksw_top uut (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CSW_EN(csw_en), .I_OSC_READY(osc_rdy),
    .O_CUR_SRC(cur_src), .O_CUR_DIV(cur_div), .O_OSC_FORCE_EN(force_en),
    .O_FRQ_SEL(frq_sel), .O_MF_HOLD(mf_hold), .O_CSW_IRQ(irq));

  cksw_osc_model osc (.i_clk(clk), .i_rst(rst), .i_run(run), .i_force_en(force_en),
    .i_frq_sel(frq_sel), .i_delay(dly), .o_ready(osc_rdy));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] exp_read(logic [7:0] a);
    case (a)
      OFF_REQ: return 32'(m_rdiv * 16 + m_rsrc);
      OFF_CUR: return 32'(m_div * 16 + m_src);
      OFF_SWCS: return 32'(m_hold * 128 + m_switch_done_ready_bit * 16 + m_new_source_ready_flag * 8);
      OFF_OSTAT: return 32'(m_run | m_oen);
      OFF_OEN: return 32'(m_oen);
      OFF_FRQ: return 32'(m_frq);
      OFF_IFLAG: return 32'(m_flag);
      OFF_IEN: return 32'(m_ien);
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_read

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  // one APB transfer; waits for pready with a bound instead of assuming zero waits
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic check_all();
    foreach (regs_q[i]) begin
      apb(1'b0, regs_q[i], 32'h0000_0000);
      chk($sformatf("reg %h", regs_q[i]), rd, exp_read(regs_q[i]));
    end
  endtask : check_all

  task automatic wait_cur(logic [2:0] s, logic [3:0] d);
    n = 0;
    while (!(cur_src === s && cur_div === d) && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_cur

  task automatic poll_ready();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_SWCS, 32'h0000_0000);
      k++;
    end while (rd[NEW_SOURCE_READY_FLAG_BIT] !== 1'b1 && k < 40);
    chk("new source ready", 32'(rd[NEW_SOURCE_READY_FLAG_BIT]), 32'h0000_0001);
  endtask : poll_ready

  task automatic end_test(string name);
    $display("test %s done, mismatches %0d", name, mismatches);
  endtask : end_test

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(10);
    check_all();
    apb(1'b1, OFF_CUR, 32'h0000_0073);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 32'(err), 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    check_all();
    end_test("reset");
    // switching disabled: request field must not move
    csw_en <= 1'b0;
    cyc(4);
    apb(1'b1, OFF_REQ, 32'h0000_0032);
    cyc(4);
    check_all();
    chk("cur src locked", 32'(cur_src), 32'h0000_0006);
    end_test("switch disabled");
    csw_en <= 1'b1;
    dly <= 8'(xs() & 32'h0000_000F);
    cyc(4);
    apb(1'b1, OFF_REQ, 32'h0000_0056);
    #1;
    chk("div before switch", 32'(cur_div), 32'h0000_0000);
    wait_cur(3'h6, 4'h5);
    chk("div latency", 32'(n), 32'h0000_0003);
    m_rdiv = 5;
    m_div = 5;
    m_flag = 1;
    check_all();
    apb(1'b1, OFF_IFLAG, 32'h0000_0001);
    m_flag = 0;
    end_test("divider only");
    apb(1'b1, OFF_SWCS, 32'h0000_0080);
    m_hold = 1;
    apb(1'b1, OFF_IEN, 32'h0000_0001);
    m_ien = 1;
    apb(1'b1, OFF_REQ, 32'h0000_0052);
    m_rsrc = 2;
    m_switch_done_ready_bit = 0;
    cyc(20);
    check_all();
    chk("old source kept", 32'(cur_src), 32'h0000_0006);
    run[2] <= 1'b1;
    m_run = m_run | 4;
    poll_ready();
    m_new_source_ready_flag = 1;
    m_flag = 1;
    cyc(3);
    chk("irq raised", 32'(irq), 32'h0000_0001);
    check_all();
    chk("held source", 32'(cur_src), 32'h0000_0006);
    apb(1'b1, OFF_SWCS, 32'h0000_0000);
    #1;
    wait_cur(3'h2, 4'h5);
    chk("release latency", 32'(n <= 2), 32'h0000_0001);
    m_hold = 0;
    m_src = 2;
    m_new_source_ready_flag = 0;
    m_switch_done_ready_bit = 1;
    check_all();
    apb(1'b1, OFF_IFLAG, 32'h0000_0001);
    m_flag = 0;
    cyc(3);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    end_test("held switch");
    apb(1'b1, OFF_SWCS, 32'h0000_0080);
    m_hold = 1;
    run[4] <= 1'b1;
    m_run = m_run | 16;
    apb(1'b1, OFF_REQ, 32'h0000_0054);
    m_rsrc = 4;
    m_switch_done_ready_bit = 0;
    poll_ready();
    // cancel by copying the current source back into the request
    apb(1'b1, OFF_REQ, 32'h0000_0052);
    m_rsrc = 2;
    m_new_source_ready_flag = 0;
    m_switch_done_ready_bit = 1;
    m_flag = 1;
    apb(1'b1, OFF_SWCS, 32'h0000_0000);
    m_hold = 0;
    cyc(5);
    check_all();
    chk("cancel keeps source", 32'(cur_src), 32'h0000_0002);
    apb(1'b1, OFF_IFLAG, 32'h0000_0001);
    m_flag = 0;
    end_test("cancel");
    m_frq = int'(xs() & 32'h0000_0007) + 8;
    apb(1'b1, OFF_FRQ, 32'(m_frq));
    cyc(2);
    chk("mid clock held", 32'(mf_hold), 32'h0000_0001);
    chk("freq select", 32'(frq_sel), 32'(m_frq));
    apb(1'b0, OFF_OSTAT, 32'h0000_0000);
    chk("internal ready cleared", rd & 32'h0000_0060, 32'h0000_0000);
    n = 0;
    while (mf_hold !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("mid clock released", 32'(mf_hold), 32'h0000_0000);
    cyc(4);
    check_all();
    end_test("frequency change");
    m_oen = int'(xs() & 32'h0000_00FF);
    apb(1'b1, OFF_OEN, 32'(m_oen));
    cyc(2);
    chk("force enables", 32'(force_en), 32'(m_oen));
    cyc(25);
    check_all();
    end_test("manual enable");
    stop_test();
  end
endmodule : cksw_tb_top
